// *** hw/mosrd_pkg.sv ***
`default_nettype none
package mosrd_pkg;
  // Timing of the main clock watchdog
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned MIN_MAIN_HZ = 2_000_000;
  // One slowest main period of silence means stopped
  localparam int unsigned STOP_CYC = CLK_HZ / MIN_MAIN_HZ;
  localparam int unsigned RESTART_EDGES = 4;

  // Register map (byte addresses)
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CLK = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_MASK = 8'h0C;

  // Monitor control fields
  localparam int unsigned CTRL_EN = 0;
  localparam int unsigned CTRL_OCS = 1;
  localparam int unsigned CTRL_FLAG = 2;
  localparam int unsigned CTRL_STOPPED = 3;
  localparam int unsigned CTRL_ACT = 7;
  // Clock source fields
  localparam int unsigned CLK_OSC_STOP = 0;
  localparam int unsigned CLK_PLL = 1;
  // Interrupt status and mask fields
  localparam int unsigned IRQ_STOP = 0;
  localparam int unsigned IRQ_REOSC = 1;
  localparam int unsigned IRQ_W = 2;

  // Reset values
  localparam logic RST_OSC_STOP = 1'b1;
  localparam logic [IRQ_W-1:0] RST_MASK = 2'h0;

  // Wishbone request and answer
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } mosrd_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } mosrd_wb_rsp_t;

  // Watchdog events
  typedef struct packed {
    logic stop;
    logic reosc;
    logic running;
  } mosrd_evt_t;

  typedef enum logic [0:0] {
    DET_RUN = 1'b0,
    DET_STOP = 1'b1
  } mosrd_det_t;
endpackage : mosrd_pkg
`default_nettype wire

// *** hw/mosrd_osc_watch.sv ***
`timescale 1ns/1ps
`default_nettype none
module mosrd_osc_watch #(
  parameter int unsigned STOP_CYC = mosrd_pkg::STOP_CYC,
  parameter int unsigned RESTART_EDGES = mosrd_pkg::RESTART_EDGES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Main clock pin
  input wire logic main_clock_input_i,
  // Events
  output var mosrd_pkg::mosrd_evt_t evt_o
);
  import mosrd_pkg::*;
  localparam int unsigned CW = $clog2(STOP_CYC + 1);
  localparam int unsigned EW = $clog2(RESTART_EDGES + 1);
  localparam logic [CW-1:0] QUIET_LAST = CW'(STOP_CYC - 1);
  localparam logic [EW-1:0] EDGE_LAST = EW'(RESTART_EDGES - 1);

  logic sync1_q, sync2_q, prev_q;
  logic [CW-1:0] quiet_q;
  logic [EW-1:0] edges_q;
  mosrd_det_t state_q;
  wire logic edge_w;
  wire logic quiet_done_w;
  wire logic restart_w;

  // Edge seen on either level change of the settled pin
  assign edge_w = sync2_q ^ prev_q;
  assign quiet_done_w = !edge_w && (quiet_q == QUIET_LAST);
  assign restart_w = edge_w && (edges_q == EDGE_LAST);

  // Pin settling; first stage feeds only the second
  always_ff @(posedge clk_i) begin
    sync1_q <= main_clock_input_i;
    sync2_q <= sync1_q;
    prev_q <= sync2_q;
  end

  // Quiet counter and restart edge counter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= DET_RUN;
      quiet_q <= '0;
      edges_q <= '0;
      evt_o <= '{stop: 1'b0, reosc: 1'b0, running: 1'b1};
    end else begin
      evt_o.stop <= 1'b0;
      evt_o.reosc <= 1'b0;
      quiet_q <= (edge_w || quiet_done_w) ? '0 : quiet_q + 1'b1;
      case (state_q)
        DET_RUN: begin
          if (quiet_done_w) begin
            state_q <= DET_STOP;
            evt_o.stop <= 1'b1;
            evt_o.running <= 1'b0;
          end
        end
        DET_STOP: begin
          // A single glitch never counts as a restart; RESTART_EDGES edges before a full quiet gap are needed
          if (restart_w) begin
            state_q <= DET_RUN;
            edges_q <= '0;
            evt_o.reosc <= 1'b1;
            evt_o.running <= 1'b1;
          end else if (edge_w) begin
            edges_q <= edges_q + 1'b1;
          end else if (quiet_done_w) begin
            edges_q <= '0;
          end
        end
        default: state_q <= DET_RUN;
      endcase
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_quiet_gap: assert property (edge_w |=> (!evt_o.stop) [*8])
    else $error("stop reported right after a main clock edge");
endmodule : mosrd_osc_watch
`default_nettype wire

// *** hw/mosrd_top.sv ***
// Added by the designer: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module mosrd_top #(
  parameter int unsigned STOP_CYC = mosrd_pkg::STOP_CYC,
  parameter int unsigned RESTART_EDGES = mosrd_pkg::RESTART_EDGES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register bus
  input wire mosrd_pkg::mosrd_wb_req_t wb_req_i,
  output var mosrd_pkg::mosrd_wb_rsp_t wb_rsp_o,
  // Main clock and system resets
  input wire logic main_clock_input_i,
  input wire logic pin_reset_i,
  input wire logic brownout_reset_i,
  // Clock control and requests
  output logic onchip_clock_select_o,
  output logic onchip_osc_run_o,
  output logic osc_stop_reset_o,
  output logic irq_o
);
  import mosrd_pkg::*;

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    hit = (adr == off);
  endfunction : hit

  mosrd_evt_t evt_w;
  logic en_q, act_q, ocs_q, flag_q, stopped_q, oscstop_q, pll_q, halt_q;
  logic en_d, act_d, ocs_d, flag_d, stopped_d, oscstop_d, pll_d;
  logic [IRQ_W-1:0] stat_q, stat_d, mask_q, mask_d;
  logic ack_q, irq_q;
  logic [31:0] rdat_q;

  mosrd_osc_watch #(
    .STOP_CYC(STOP_CYC),
    .RESTART_EDGES(RESTART_EDGES)
  ) u_watch (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .main_clock_input_i(main_clock_input_i),
    .evt_o(evt_w)
  );

  // Bus decode; writes land on the acknowledging edge
  wire logic req_w = wb_req_i.cyc && wb_req_i.stb;
  wire logic wr_w = req_w && wb_req_i.we && ack_q && wb_req_i.sel[0];
  wire logic wr_ctrl_w = wr_w && hit(wb_req_i.adr, OFF_CTRL);
  wire logic wr_clk_w = wr_w && hit(wb_req_i.adr, OFF_CLK);
  wire logic wr_stat_w = wr_w && hit(wb_req_i.adr, OFF_STAT);
  wire logic wr_mask_w = wr_w && hit(wb_req_i.adr, OFF_MASK);
  wire logic [31:0] wd_w = wb_req_i.dat;

  // Events only count while monitoring is enabled
  wire logic ev_stop_w = en_q && evt_w.stop;
  wire logic ev_reosc_w = en_q && evt_w.reosc;
  wire logic int_stop_w = ev_stop_w && act_q;
  wire logic int_reosc_w = ev_reosc_w && act_q;
  // Reset action on either detection
  wire logic go_halt_w = !act_q && (ev_stop_w || ev_reosc_w);
  wire logic release_w = rst_i || pin_reset_i || brownout_reset_i;
  // Halt re-initialises every register of the register file below
  wire logic init_w = rst_i || halt_q;

  // Control field updates; hardware update beats software write
  assign en_d = wr_ctrl_w ? wd_w[CTRL_EN] : en_q;
  assign act_d = wr_ctrl_w ? wd_w[CTRL_ACT] : act_q;
  assign pll_d = wr_clk_w ? wd_w[CLK_PLL] : pll_q;
  assign ocs_d = (int_stop_w && !pll_q) ? 1'b1 :
                 wr_ctrl_w ? wd_w[CTRL_OCS] : ocs_q;
  assign flag_d = (int_stop_w || int_reosc_w) ? 1'b1 :
                  (wr_ctrl_w && !wd_w[CTRL_FLAG]) ? 1'b0 : flag_q;
  assign stopped_d = int_stop_w ? 1'b1 : int_reosc_w ? 1'b0 : stopped_q;
  assign oscstop_d = (int_stop_w || int_reosc_w) ? 1'b0 :
                     wr_clk_w ? wd_w[CLK_OSC_STOP] : oscstop_q;

  // Sticky status, write one to clear, new event wins
  assign stat_d = (stat_q & ~(wr_stat_w ? wd_w[IRQ_W-1:0] : {IRQ_W{1'b0}}))
                  | {int_reosc_w, int_stop_w};
  assign mask_d = wr_mask_w ? wd_w[IRQ_W-1:0] : mask_q;

  // Read data assembly; unmapped offsets read zero
  wire logic [7:0] ctrl_rd_w = {act_q, 3'h0, stopped_q, flag_q, ocs_q, en_q};
  wire logic [31:0] rd_w =
    hit(wb_req_i.adr, OFF_CTRL) ? {24'h0, ctrl_rd_w} :
    hit(wb_req_i.adr, OFF_CLK) ? {30'h0, pll_q, oscstop_q} :
    hit(wb_req_i.adr, OFF_STAT) ? {30'h0, stat_q} :
    hit(wb_req_i.adr, OFF_MASK) ? {30'h0, mask_q} : 32'h0;

  // Bus answer one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0;
    end else begin
      ack_q <= req_w && !ack_q;
      rdat_q <= rd_w;
    end
  end

  // Halt is kept through its own initialisation
  always_ff @(posedge clk_i) begin
    if (release_w) begin
      halt_q <= 1'b0;
    end else if (go_halt_w) begin
      halt_q <= 1'b1;
    end
  end

  // Register file
  always_ff @(posedge clk_i) begin
    if (init_w) begin
      en_q <= 1'b0;
      act_q <= 1'b0;
      ocs_q <= 1'b0;
      flag_q <= 1'b0;
      stopped_q <= 1'b0;
      oscstop_q <= RST_OSC_STOP;
      pll_q <= 1'b0;
      stat_q <= '0;
      mask_q <= RST_MASK;
      irq_q <= 1'b0;
    end else begin
      en_q <= en_d;
      act_q <= act_d;
      ocs_q <= ocs_d;
      flag_q <= flag_d;
      stopped_q <= stopped_d;
      oscstop_q <= oscstop_d;
      pll_q <= pll_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      irq_q <= |(stat_q & mask_q);
    end
  end

  // Outputs straight from flops
  assign wb_rsp_o = '{ack: ack_q, dat: rdat_q};
  assign onchip_clock_select_o = ocs_q;
  assign onchip_osc_run_o = !oscstop_q;
  assign osc_stop_reset_o = halt_q;
  assign irq_o = irq_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_int_stop;
    en_q && act_q && evt_w.stop && !halt_q;
  endsequence
  sequence s_int_reosc;
    en_q && act_q && evt_w.reosc && !halt_q;
  endsequence

  a_disabled_quiet: assert property (
    !en_q && !halt_q |=> !$rose(halt_q) && !$rose(flag_q) && !$rose(stopped_q))
    else $error("monitor acted while disabled");
  a_stop_halts: assert property (
    en_q && !act_q && evt_w.stop && !pin_reset_i && !brownout_reset_i
      |=> halt_q ##1 !en_q)
    else $error("reset mode stop did not halt and initialise");
  a_halt_holds: assert property (
    halt_q && !pin_reset_i && !brownout_reset_i |=> halt_q)
    else $error("halt released without a reset");
  a_reosc_halts: assert property (
    en_q && !act_q && evt_w.reosc && !pin_reset_i && !brownout_reset_i |=> halt_q)
    else $error("reset mode restart did not halt");
  a_int_no_halt: assert property (
    en_q && act_q && !halt_q && !pin_reset_i && !brownout_reset_i |=> !halt_q)
    else $error("interrupt mode halted the device");
  a_stop_switch: assert property (
    s_int_stop ##0 !pll_q ##1 mask_q[IRQ_STOP]
      |-> ocs_q && flag_q && stopped_q && !oscstop_q && stat_q[IRQ_STOP] ##1 irq_q)
    else $error("interrupt mode stop effects missing");
  a_pll_keeps_sel: assert property (
    s_int_stop ##0 pll_q && !wr_ctrl_w |=> ocs_q == $past(ocs_q) && stopped_q && flag_q)
    else $error("clock select changed under PLL source");
  a_reosc_clears: assert property (
    s_int_reosc ##0 !wr_ctrl_w |=> !stopped_q && flag_q && !oscstop_q && stat_q[IRQ_REOSC]
      && ocs_q == $past(ocs_q))
    else $error("restart effects missing");
  a_stop_not_running: assert property (
    evt_w.stop |-> !evt_w.running)
    else $error("stop event while the watchdog reports running");
  a_flag_sticky: assert property (
    flag_q && !halt_q && !go_halt_w && !(wr_ctrl_w && !wd_w[CTRL_FLAG]) |=> flag_q)
    else $error("detection flag dropped without a zero write");
endmodule : mosrd_top
`default_nettype wire

// *** verification/mosrd_osc_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module mosrd_osc_model (
  // Bench clock and control
  input wire logic clk_i,
  input wire logic run_i,
  input wire logic [3:0] half_i,
  // Oscillator pin
  output logic pin_o = 1'b0
);
  logic [3:0] cnt_q = 4'h0;

  // A stopped crystal freezes at its last level, it does not float
  always @(posedge clk_i) begin
    if (run_i && cnt_q >= half_i) begin
      cnt_q <= 4'h0;
      pin_o <= ~pin_o;
    end else if (run_i) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule : mosrd_osc_model
`default_nettype wire

// *** verification/mosrd_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module mosrd_bench;
  import mosrd_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  mosrd_wb_req_t req = '0;
  mosrd_wb_rsp_t rsp;
  logic pin;
  logic run = 1'b1;
  logic pin_rst = 1'b0;
  logic bo_rst = 1'b0;
  logic [3:0] half = 4'h3;
  logic ocs, orun, halt, irq;
  logic [31:0] rd;
  int err_count = 0;
  int checks_done = 0;
  // Reference register state
  int m_ctrl = 0, m_clk = 1, m_stat = 0, m_mask = 0, m_halt = 0;

  // 200 MHz clock
  always #2.5 clk_i = ~clk_i;

  mosrd_osc_model i_mosrd_osc_model (.clk_i(clk_i), .run_i(run), .half_i(half), .pin_o(pin));
  // Short silence window keeps the run brief
  mosrd_top #(.STOP_CYC(20), .RESTART_EDGES(4)) i_mosrd_top (.clk_i(clk_i), .rst_i(rst_i),
    .wb_req_i(req), .wb_rsp_o(rsp), .main_clock_input_i(pin), .pin_reset_i(pin_rst),
    .brownout_reset_i(bo_rst), .onchip_clock_select_o(ocs), .onchip_osc_run_o(orun),
    .osc_stop_reset_o(halt), .irq_o(irq));

  task automatic finish_test();
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_reg

  task automatic cmp_pin(input logic got, input logic exp);
    cmp_reg({31'h0, got}, {31'h0, exp});
  endtask : cmp_pin

  // Classic cycle; ack is read before this edge's updates land
  // No local limit: only the hang guard ends a stalled wait
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    req <= '{1'b1, 1'b1, we, a, 4'hF, d};
    do begin
      @(posedge clk_i);
    end while (rsp.ack !== 1'b1);
    rd = rsp.dat;
    req <= '0;
  endtask : wb

  task automatic wr(input logic [7:0] a, input int d);
    wb(1'b1, a, 32'(d));
    if (m_halt == 0) begin
      case (a)
        OFF_CTRL: m_ctrl = (d & 'h83) | (m_ctrl & 'h8) | (m_ctrl & d & 'h4);
        OFF_CLK: m_clk = d & 3;
        OFF_STAT: m_stat &= ~d;
        OFF_MASK: m_mask = d & 3;
        default: ;
      endcase
    end
  endtask : wr

  task automatic chk(input logic [7:0] a);
    wb(1'b0, a, 32'h0);
    cmp_reg(rd, 32'(a == OFF_CTRL ? m_ctrl : a == OFF_CLK ? m_clk :
      a == OFF_STAT ? m_stat : a == OFF_MASK ? m_mask : 0));
  endtask : chk

  task automatic chk_all();
    chk(OFF_CTRL);
    chk(OFF_CLK);
    chk(OFF_STAT);
    cmp_pin(irq, (m_stat & m_mask) != 0);
  endtask : chk_all

  // Start or stop the crystal, then apply the expected reaction
  task automatic osc(input logic on);
    run <= on;
    repeat (45) @(posedge clk_i);
    if (m_ctrl[0] && !m_ctrl[7]) begin
      m_halt = 1;
      m_ctrl = 0;
      m_clk = 1;
      m_stat = 0;
      m_mask = 0;
    end else if (m_ctrl[0]) begin
      m_clk &= 2;
      m_stat |= on ? 2 : 1;
      if (on) m_ctrl = (m_ctrl | 4) & 'hF7;
      else m_ctrl |= m_clk[1] ? 'hC : 'hE;
    end
  endtask : osc

  task automatic rel(input logic bo);
    if (bo) bo_rst <= 1'b1;
    else pin_rst <= 1'b1;
    @(posedge clk_i);
    pin_rst <= 1'b0;
    bo_rst <= 1'b0;
    repeat (4) @(posedge clk_i);
    m_halt = 0;
  endtask : rel

  // Main sequence
  initial begin
    void'($urandom(32'h19D5));
    half = 4'($urandom_range(5, 2));
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    chk_all();
    chk(OFF_MASK);
    wr(8'h10, int'($urandom));
    chk(8'h10);
    osc(1'b0);
    chk_all();
    osc(1'b1);
    wr(OFF_MASK, 3);
    wr(OFF_CTRL, 'h81);
    osc(1'b0);
    chk_all();
    cmp_pin(ocs, 1'b1);
    cmp_pin(orun, 1'b1);
    wr(OFF_CTRL, 'h83);
    chk(OFF_CTRL);
    wr(OFF_STAT, 1);
    chk_all();
    osc(1'b1);
    chk_all();
    cmp_pin(ocs, 1'b1);
    wr(OFF_CTRL, 'h81);
    wr(OFF_STAT, 3);
    wr(OFF_CLK, 3);
    osc(1'b0);
    chk_all();
    cmp_pin(ocs, 1'b0);
    wr(OFF_CTRL, 'h83);
    chk(OFF_CTRL);
    osc(1'b1);
    wr(OFF_CTRL, 'h01);
    osc(1'b0);
    cmp_pin(halt, 1'b1);
    osc(1'b1);
    wr(OFF_CTRL, 'h81);
    cmp_pin(halt, 1'b1);
    chk(OFF_CTRL);
    rel(1'b0);
    cmp_pin(halt, 1'b0);
    wr(OFF_CTRL, 'h01);
    osc(1'b0);
    cmp_pin(halt, 1'b1);
    rel(1'b1);
    cmp_pin(halt, 1'b0);
    finish_test();
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    finish_test();
  end
endmodule : mosrd_bench
`default_nettype wire
